// [hw/icr_pkg.sv]
// Package: constants and types of the two-wire bus control registers
package icr_pkg;

  // ----------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_CTRL_ONE = 16'hF078;
  localparam logic [15:0] IDX_CTRL_TWO = 16'hF079;
  localparam logic [15:0] IDX_MODE_SET = 16'hF07A;
  localparam int ADDR_LSB = 2;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ONE_ENABLE = 7;
  localparam int ONE_RX_DIS = 6;
  localparam int ONE_MASTER = 5;
  localparam int ONE_TX_SEL = 4;
  localparam int TWO_BUSY = 7;
  localparam int TWO_SDA_CTRL = 5;
  localparam int TWO_SDA_PROT = 4;

  // ----------------------------------------------------------------
  // Reset values and the fixed read value of the protect bit
  // ----------------------------------------------------------------
  localparam logic RST_ENABLE = 1'h0;
  localparam logic RST_RX_DIS = 1'h0;
  localparam logic RST_MASTER = 1'h0;
  localparam logic RST_TX_SEL = 1'h0;
  localparam logic RST_SDA_CTRL = 1'h1;
  localparam logic [7:0] RST_MODE_SET = 8'h00;
  localparam logic PROT_READ = 1'h1;

  // Operating modes, in the order of the two select bits
  typedef enum logic [1:0] {
    SLAVE_RX,
    SLAVE_TX,
    MASTER_RX,
    MASTER_TX
  } icr_mode_e;

  // Status and requests from the transfer engine, same clock
  typedef struct packed {
    logic arbLost;
    logic i2cFormat;
    logic rxDataRead;
    logic transferBusy;
    logic engSdaLow;
    logic engSclLow;
  } icr_engine_s;

  // Controls handed to the transfer engine
  typedef struct packed {
    logic moduleEnable;
    icr_mode_e mode;
    logic rxNextStart;
    logic [7:0] modeSetting;
  } icr_ctrl_s;

endpackage : icr_pkg

// [hw/icr_control_regs.sv]
// Control registers of the two-wire bus interface, Wishbone slave
// What this block does
// - Enable bit clear halts module and returns both pins to port function.
// - Enable bit set allows transfers and hands both pins to the bus.
// - After receive data read in receive direction, next reception only if enabled.
// - Master and transmit bits decode to the four slave/master rx/tx modes.
// - Lost arbitration in master mode, standard format, clears both select bits.
// - Data-line output bit reads back its last accepted value, not the pin level.
// - Accepted write 0 drives data pin low; write 1 releases it high.
// - Data-line output bit changes only when same write clears protect bit.
// - The protect bit always reads as 1.
//
// The Wishbone register port is this design's own decision.
module icr_control_regs #(
  parameter int ADDR_W = 18
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire icr_pkg::icr_engine_s engine,
  output icr_pkg::icr_ctrl_s ctrl,
  input wire logic sclPin,
  input wire logic sdaPin,
  output logic sclLevel,
  output logic sdaLevel,
  output logic sclOut,
  output logic sclOe,
  output logic sdaOut,
  output logic sdaOe,
  output logic pinsToBus
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic moduleEnable;
    logic receptionDisable;
    logic masterSelect;
    logic transmitSelect;
    logic dataLineOutputCtrl;
    logic [7:0] modeSetting;
    logic rxNextStart;
    logic ack;
    logic [7:0] rdData;
    logic [1:0] sclSync;
    logic [1:0] sdaSync;
  } icr_state_s;

  icr_state_s st;
  icr_state_s next_st;
  logic [1:0] rstSync;
  logic rstN;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // mode decode
  function automatic icr_pkg::icr_mode_e decodeMode(
    input logic master,
    input logic transmit
  );
    unique case ({master, transmit})
      2'h0: decodeMode = icr_pkg::SLAVE_RX;
      2'h1: decodeMode = icr_pkg::SLAVE_TX;
      2'h2: decodeMode = icr_pkg::MASTER_RX;
      2'h3: decodeMode = icr_pkg::MASTER_TX;
    endcase
  endfunction : decodeMode

  function automatic logic hitIndex(
    input logic [ADDR_W-1:0] adr,
    input logic [15:0] idx
  );
    hitIndex = (adr[ADDR_W-1:icr_pkg::ADDR_LSB] ==
      (ADDR_W-icr_pkg::ADDR_LSB)'(idx));
  endfunction : hitIndex

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'h1};
    end
  end

  assign rstN = rstSync[1];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic req;
  logic wrLane0;
  logic hitOne;
  logic hitTwo;
  logic hitMode;
  logic [7:0] wrByte;

  assign req = wb_cyc_i && wb_stb_i && !st.ack;
  assign wrLane0 = req && wb_we_i && wb_sel_i[0];
  assign hitOne = hitIndex(wb_adr_i, icr_pkg::IDX_CTRL_ONE);
  assign hitTwo = hitIndex(wb_adr_i, icr_pkg::IDX_CTRL_TWO);
  assign hitMode = hitIndex(wb_adr_i, icr_pkg::IDX_MODE_SET);
  assign wrByte = wb_dat_i[7:0];

  always_comb begin
    next_st = st;
    next_st.ack = req;
    next_st.sclSync = {st.sclSync[0], sclPin};
    next_st.sdaSync = {st.sdaSync[0], sdaPin};

    if (wrLane0 && hitOne) begin
      next_st.moduleEnable = wrByte[icr_pkg::ONE_ENABLE];
      next_st.receptionDisable = wrByte[icr_pkg::ONE_RX_DIS];
      next_st.masterSelect = wrByte[icr_pkg::ONE_MASTER];
      next_st.transmitSelect = wrByte[icr_pkg::ONE_TX_SEL];
    end

    // protect bit must be cleared by the same write
    if (wrLane0 && hitTwo && !wrByte[icr_pkg::TWO_SDA_PROT]) begin
      next_st.dataLineOutputCtrl = wrByte[icr_pkg::TWO_SDA_CTRL];
    end

    if (wrLane0 && hitMode) begin
      next_st.modeSetting = wrByte;
    end

    // lost arbitration beats a software write in the same cycle
    if (engine.arbLost && st.masterSelect && engine.i2cFormat) begin
      next_st.masterSelect = 1'h0;
      next_st.transmitSelect = 1'h0;
    end

    // next reception gated by the disable bit
    next_st.rxNextStart = engine.rxDataRead && st.moduleEnable &&
      !st.transmitSelect && !st.receptionDisable;

    next_st.rdData = 8'h00;
    if (req && !wb_we_i) begin
      if (hitOne) begin
        next_st.rdData[icr_pkg::ONE_ENABLE] = st.moduleEnable;
        next_st.rdData[icr_pkg::ONE_RX_DIS] = st.receptionDisable;
        next_st.rdData[icr_pkg::ONE_MASTER] = st.masterSelect;
        next_st.rdData[icr_pkg::ONE_TX_SEL] = st.transmitSelect;
      end else if (hitTwo) begin
        next_st.rdData[icr_pkg::TWO_BUSY] = engine.transferBusy;
        // reads the stored output control bit, not the pin level
        next_st.rdData[icr_pkg::TWO_SDA_CTRL] = st.dataLineOutputCtrl;
        next_st.rdData[icr_pkg::TWO_SDA_PROT] = icr_pkg::PROT_READ;
      end else if (hitMode) begin
        next_st.rdData = st.modeSetting;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      st <= '0;
      st.moduleEnable <= icr_pkg::RST_ENABLE;
      st.receptionDisable <= icr_pkg::RST_RX_DIS;
      st.masterSelect <= icr_pkg::RST_MASTER;
      st.transmitSelect <= icr_pkg::RST_TX_SEL;
      st.dataLineOutputCtrl <= icr_pkg::RST_SDA_CTRL;
      st.modeSetting <= icr_pkg::RST_MODE_SET;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign wb_ack_o = st.ack;
  assign wb_dat_o = {24'h000000, st.rdData};

  assign ctrl.moduleEnable = st.moduleEnable;
  assign ctrl.mode = decodeMode(st.masterSelect, st.transmitSelect);
  assign ctrl.rxNextStart = st.rxNextStart;
  assign ctrl.modeSetting = st.modeSetting;

  // disabled module lets go of both pins
  assign pinsToBus = st.moduleEnable;
  assign sclLevel = st.sclSync[1];
  assign sdaLevel = st.sdaSync[1];

  // Open drain: only ever drive low
  assign sclOut = 1'h0;
  assign sdaOut = 1'h0;
  assign sclOe = st.moduleEnable && engine.engSclLow;
  // bit low pulls the line, bit high releases it
  assign sdaOe = st.moduleEnable &&
    (!st.dataLineOutputCtrl || engine.engSdaLow);

endmodule : icr_control_regs

// [verif/icr_bus_peer.sv]
// Open-drain bus peer: pull-ups and a device that may pull data low
module icr_bus_peer (
  input wire logic sdaOe,
  input wire logic sclOe,
  input wire logic peerSdaLow,
  output logic sdaPin,
  output logic sclPin
);
  timeunit 1ns;
  timeprecision 100ps;
  // released line floats high by pull-up
  assign sdaPin = !(sdaOe || peerSdaLow);
  assign sclPin = !sclOe;
endmodule : icr_bus_peer

// [verif/icr_control_regs_chk.sv]
// Port checker of the control register block
module icr_control_regs_chk #(
  parameter int ADDR_W = 18
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire icr_pkg::icr_engine_s engine,
  input wire icr_pkg::icr_ctrl_s ctrl,
  input wire logic sdaOut,
  input wire logic sclOe,
  input wire logic sdaOe,
  input wire logic pinsToBus
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence sTaken;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence sArbLoss;
    engine.arbLost && engine.i2cFormat && ctrl.mode[1];
  endsequence
  bus_answer_a: assert property (sTaken |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle after request");
  read_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  halt_pins_a: assert property (
    !ctrl.moduleEnable |-> !pinsToBus && !sdaOe && !sclOe)
    else $error("pins not returned while halted");
  bus_pins_a: assert property (
    ctrl.moduleEnable |-> pinsToBus && sclOe == engine.engSclLow)
    else $error("pins not bus driven while enabled");
  sda_drive_a: assert property (
    ctrl.moduleEnable && engine.engSdaLow |-> sdaOe && !sdaOut)
    else $error("data line not pulled low");
  rx_start_a: assert property (ctrl.rxNextStart |->
    $past(engine.rxDataRead) && !$past(ctrl.mode[0]))
    else $error("next reception without receive read");
  rx_pulse_a: assert property (
    ctrl.rxNextStart && !engine.rxDataRead |=> !ctrl.rxNextStart)
    else $error("reception start longer than one cycle");
  arb_clear_a: assert property (sArbLoss |=> ctrl.mode == 2'h0)
    else $error("mode not slave receive after lost arbitration");
  arb_keep_a: assert property (
    engine.arbLost && !engine.i2cFormat && !wb_cyc_i |=> $stable(ctrl.mode))
    else $error("mode changed outside standard format");
endmodule : icr_control_regs_chk
bind icr_control_regs icr_control_regs_chk #(.ADDR_W(ADDR_W)) u_chk (
  .core_clk(core_clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .engine(engine), .ctrl(ctrl), .sdaOut(sdaOut), .sclOe(sclOe),
  .sdaOe(sdaOe), .pinsToBus(pinsToBus));

// [verif/icr_control_regs_tb_top.sv]
// Self-checking bench of the control register block
module icr_control_regs_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [17:0] aOne = 18'(icr_pkg::IDX_CTRL_ONE) << 2;
  localparam logic [17:0] aTwo = 18'(icr_pkg::IDX_CTRL_TWO) << 2;
  localparam logic [17:0] aMode = 18'(icr_pkg::IDX_MODE_SET) << 2;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, peerLow = 1'b0;
  logic [3:0] sel = 4'h1;
  logic [17:0] adr = 18'h0;
  logic [31:0] wdat = 32'h0, rdat;
  logic [7:0] q;
  logic [7:0] rxCfg [4] = '{8'h80, 8'hC0, 8'h90, 8'h00};
  logic ack, sdaPin, sclPin, sclOut, sclOe, sdaOut, sdaOe;
  logic sclLevel, sdaLevel, pinsToBus;
  icr_pkg::icr_engine_s eng = '0;
  icr_pkg::icr_ctrl_s ctrl;
  int errors = 0, cmp_count = 0;
  always #12.5 core_clk = !core_clk;
  icr_control_regs u_dut (.core_clk(core_clk), .arst_n(arst_n),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .engine(eng), .ctrl(ctrl), .sclPin(sclPin), .sdaPin(sdaPin),
    .sclLevel(sclLevel), .sdaLevel(sdaLevel), .sclOut(sclOut),
    .sclOe(sclOe), .sdaOut(sdaOut), .sdaOe(sdaOe), .pinsToBus(pinsToBus));
  icr_bus_peer u_peer (.sdaOe(sdaOe), .sclOe(sclOe), .peerSdaLow(peerLow),
    .sdaPin(sdaPin), .sclPin(sclPin));
  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic bus(input logic w, input logic [17:0] a,
                     input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do @(posedge core_clk); while (ack !== 1'b1);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge core_clk);
  endtask : bus
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rdc(input logic [17:0] a, input logic [7:0] m,
                     input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(q & m, e);
  endtask : rdc
  // Engine pulse lasting one cycle, result checked once it has landed
  task automatic pulse(input int which);
    if (which == 0) eng.rxDataRead <= 1'b1;
    else eng.arbLost <= 1'b1;
    @(posedge core_clk);
    eng.rxDataRead <= 1'b0;
    eng.arbLost <= 1'b0;
    @(posedge core_clk);
  endtask : pulse
  task give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    rdc(aOne, 8'hF0, 8'h00);
    rdc(aTwo, 8'hB0, 8'h30);
    chk(8'(pinsToBus), 8'h00);
    $display("test 1 done");
    eng.engSclLow <= 1'b1;
    eng.engSdaLow <= 1'b1;
    bus(1'b1, aOne, 8'h80);
    chk({6'h0, pinsToBus, sclOe}, 8'h03);
    chk(8'(sdaOe), 8'h01);
    chk({6'h0, sclOut, sdaOut}, 8'h00);
    repeat (3) @(posedge core_clk);
    chk({6'h0, sclLevel, sdaLevel}, 8'h00);
    bus(1'b1, aOne, 8'h00);
    chk({5'h0, pinsToBus, sclOe, sdaOe}, 8'h00);
    eng.engSclLow <= 1'b0;
    eng.engSdaLow <= 1'b0;
    $display("test 2 done");
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, aOne, 8'(8'h80 | (m << 4)));
      chk(8'(ctrl.mode), 8'(m));
      rdc(aOne, 8'hF0, 8'(8'h80 | (m << 4)));
    end
    $display("test 3 done");
    bus(1'b1, aOne, 8'h80);
    bus(1'b1, aTwo, 8'h10);
    chk(8'(sdaOe), 8'h00);
    bus(1'b1, aTwo, 8'h00);
    chk(8'(sdaOe), 8'h01);
    repeat (3) @(posedge core_clk);
    chk(8'(sdaLevel), 8'h00);
    rdc(aTwo, 8'h30, 8'h10);
    bus(1'b1, aTwo, 8'h30);
    chk(8'(sdaOe), 8'h01);
    sel <= 4'h0;
    bus(1'b1, aTwo, 8'h20);
    sel <= 4'h1;
    chk(8'(sdaOe), 8'h01);
    bus(1'b1, aTwo, 8'h20);
    chk(8'(sdaOe), 8'h00);
    rdc(aTwo, 8'h30, 8'h30);
    eng.transferBusy <= 1'b1;
    rdc(aTwo, 8'h80, 8'h80);
    eng.transferBusy <= 1'b0;
    peerLow <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk(8'(sdaLevel), 8'h00);
    rdc(aTwo, 8'h20, 8'h20);
    peerLow <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk(8'(sdaLevel), 8'h01);
    $display("test 4 done");
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, aOne, rxCfg[i]);
      pulse(0);
      chk(8'(ctrl.rxNextStart), 8'(i == 0));
    end
    $display("test 5 done");
    bus(1'b1, aOne, 8'hB0);
    pulse(1);
    chk(8'(ctrl.mode), 8'h03);
    eng.i2cFormat <= 1'b1;
    pulse(1);
    chk(8'(ctrl.mode), 8'h00);
    rdc(aOne, 8'h30, 8'h00);
    bus(1'b1, aMode, 8'h5A);
    chk(ctrl.modeSetting, 8'h5A);
    rdc(aMode, 8'hFF, 8'h5A);
    rdc(18'h0, 8'hFF, 8'h00);
    $display("test 6 done");
    give_verdict();
  end
  // Bound well above the roughly 130 cycles the tests need
  initial begin
    #(25 * 4000);
    errors++;
    give_verdict();
  end
endmodule : icr_control_regs_tb_top
